// >>> hdl/crsc_consts.svh
// Purpose: Shared constants of the clock, reset and strap controller
// Assumes: clk_in is the 50 MHz oscillator clock
// Notes: What follows lists the block's behaviour
`ifndef CRSC_CONSTS_SVH
`define CRSC_CONSTS_SVH

`define CRSC_CLK_MHZ 50
`define CRSC_RESET_VECTOR 24'h000000
`define CRSC_RST_HOLD 4'h8
`define CRSC_PLL_LOCK_US 100
`define CRSC_PLL_LOCK_CYC (`CRSC_PLL_LOCK_US * `CRSC_CLK_MHZ)
`define CRSC_TB_DIV 256
`define CRSC_WDT_BITS 8
`define CRSC_MULT_LOW_FREQ 3'h4
`define CRSC_MULT_HIGH_FREQ 3'h2

// Bit positions inside the synchronised pin vector
`define CRSC_PIN_RST 0
`define CRSC_PIN_BUS 1
`define CRSC_PIN_ROM 2
`define CRSC_PIN_DBG 3
`define CRSC_PIN_LOOP 4
`define CRSC_PIN_FREQ 5
`define CRSC_PIN_COUNT 6
`define CRSC_PIN_RESET_VAL 6'h00

`endif

// >>> hdl/crsc_pkg.sv
// Purpose: Types of the clock, reset and strap controller
// Assumes: Nothing beyond the constants header
// Notes: One-hot state codes are written out
`default_nettype none
package crsc_pkg;

  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_LOCK = 4'h2,
    ST_RUN = 4'h4,
    ST_HALT = 4'h8
  } crsc_state_t;

  typedef enum logic [1:0] {
    DIV_1 = 2'h0,
    DIV_2 = 2'h1,
    DIV_4 = 2'h2
  } crsc_div_t;

endpackage : crsc_pkg
`default_nettype wire

// >>> hdl/crsc_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to clk_in
// Notes: Output moves only when stages two and three agree
`default_nettype none
module crsc_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_sync;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_sync[i] = sync_out[i];
        if (s2[i] == s3[i]) begin
          next_sync[i] = s3[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_sync;
    end
  end

endmodule : crsc_sync
`default_nettype wire

// >>> hdl/crsc_wdog.sv
// Purpose: Time base divider and watchdog counter
// Assumes: rst_in is also raised during every system reset
// Notes: Watchdog counts only while run_in is high
`include "crsc_consts.svh"
`default_nettype none
module crsc_wdog #(
  parameter int TB_DIV = `CRSC_TB_DIV,
  parameter int WDT_BITS = `CRSC_WDT_BITS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  input wire logic enable_in,
  input wire logic clear_in,
  // Results
  output logic tb_tick_out,
  output logic overflow_out
);

  localparam int TBW = $clog2(TB_DIV);

  logic [TBW-1:0] tb_cnt;
  logic [TBW-1:0] next_tb_cnt;
  logic next_tick;
  logic [WDT_BITS-1:0] wd_cnt;
  logic [WDT_BITS-1:0] next_wd_cnt;
  logic next_overflow;

  always_comb begin
    next_tick = 1'b0;
    next_tb_cnt = tb_cnt + 1'b1;
    if (tb_cnt == TBW'(TB_DIV - 1)) begin
      next_tb_cnt = '0;
      next_tick = 1'b1;
    end
    next_wd_cnt = wd_cnt;
    next_overflow = 1'b0;
    if (clear_in || !enable_in) begin
      next_wd_cnt = '0;
    end else if (run_in && tb_tick_out) begin
      next_wd_cnt = wd_cnt + 1'b1;
      if (&wd_cnt) begin
        next_overflow = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tb_cnt <= '0;
      tb_tick_out <= 1'b0;
      wd_cnt <= '0;
      overflow_out <= 1'b0;
    end else begin
      tb_cnt <= next_tb_cnt;
      tb_tick_out <= next_tick;
      wd_cnt <= next_wd_cnt;
      overflow_out <= next_overflow;
    end
  end

  a_tick_spacing: assert property (
    @(posedge clk_in) disable iff (rst_in)
    tb_tick_out |=> !tb_tick_out)
    else $error("time base ticks back to back");

  a_wdog_overflow: assert property (
    @(posedge clk_in) disable iff (rst_in)
    overflow_out |-> $past(&wd_cnt) && $past(tb_tick_out)
      && $past(run_in) && $past(enable_in) && !$past(clear_in))
    else $error("watchdog overflow without full count");

endmodule : crsc_wdog
`default_nettype wire

// >>> hdl/crsc_top.sv
// Purpose: System reset, strap capture and clock control
// Assumes: Reset pin and straps are asynchronous board pins
// Notes: Loop lock and clock gating are modelled as counts and enables
`include "crsc_consts.svh"
`default_nettype none
module crsc_top #(
  parameter int unsigned LOCK_CYCLES = `CRSC_PLL_LOCK_CYC,
  parameter int TB_DIV = `CRSC_TB_DIV,
  parameter int WDT_BITS = `CRSC_WDT_BITS
) (
  // Clock and power-on reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Board pins
  input wire logic system_reset_in_n,
  input wire logic boot_bus_width_strap_in,
  input wire logic internal_rom_enable_strap_in,
  input wire logic debug_select_strap_in,
  input wire logic loop_enable_strap_in,
  input wire logic base_freq_range_strap_in,
  // Core control, same clock
  input wire logic [1:0] clock_divider_select_in,
  input wire logic halt_request_in,
  input wire logic wake_event_in,
  input wire logic watchdog_enable_in,
  input wire logic watchdog_clear_in,
  // Reset and restart
  output logic system_reset_out,
  output logic fetch_start_out,
  output logic [23:0] fetch_address_out,
  output logic watchdog_reset_cause_out,
  // Latched strap results
  output logic bus_width_16_out,
  output logic internal_rom_enable_out,
  output logic [7:0] port_eight_pins_debug_out,
  output logic loop_enable_out,
  output logic [2:0] loop_multiplier_out,
  // Clocks and standby
  output logic system_clock_out,
  output logic cpu_clock_enable_out,
  output logic halted_out,
  output logic time_base_tick_out
);

  logic [`CRSC_PIN_COUNT-1:0] pins;
  logic [`CRSC_PIN_COUNT-1:0] pin_s;
  logic pin_rst_n;
  logic tb_tick;
  logic wd_overflow;
  logic wd_rst;

  crsc_pkg::crsc_state_t state;
  crsc_pkg::crsc_state_t next_state;
  logic [3:0] rst_cnt;
  logic [3:0] next_rst_cnt;
  logic [15:0] lock_cnt;
  logic [15:0] next_lock_cnt;
  logic next_fetch_start;
  logic next_cause;
  logic next_bus16;
  logic next_rom;
  logic next_dbg;
  logic next_loop;
  logic [2:0] next_mult;

  crsc_pkg::crsc_div_t div_sel;
  crsc_pkg::crsc_div_t next_div_sel;
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic op_tick;
  logic next_clk_out;

  assign pins[`CRSC_PIN_RST] = system_reset_in_n;
  assign pins[`CRSC_PIN_BUS] = boot_bus_width_strap_in;
  assign pins[`CRSC_PIN_ROM] = internal_rom_enable_strap_in;
  assign pins[`CRSC_PIN_DBG] = debug_select_strap_in;
  assign pins[`CRSC_PIN_LOOP] = loop_enable_strap_in;
  assign pins[`CRSC_PIN_FREQ] = base_freq_range_strap_in;
  assign pin_rst_n = pin_s[`CRSC_PIN_RST];

  crsc_sync #(
    .WIDTH(`CRSC_PIN_COUNT),
    .RESET_VAL(`CRSC_PIN_RESET_VAL)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(pins),
    .sync_out(pin_s)
  );

  // Time base and watchdog restart together with the system
  assign wd_rst = rst_in || (state == crsc_pkg::ST_RESET);

  crsc_wdog #(
    .TB_DIV(TB_DIV),
    .WDT_BITS(WDT_BITS)
  ) u_wdog (
    .clk_in(clk_in),
    .rst_in(wd_rst),
    .run_in(state == crsc_pkg::ST_RUN),
    .enable_in(watchdog_enable_in),
    .clear_in(watchdog_clear_in),
    .tb_tick_out(tb_tick),
    .overflow_out(wd_overflow)
  );

  // Reset, lock and standby sequencing
  always_comb begin
    next_state = state;
    next_rst_cnt = rst_cnt;
    next_lock_cnt = lock_cnt;
    next_fetch_start = 1'b0;
    next_cause = watchdog_reset_cause_out;
    case (state)
      crsc_pkg::ST_RESET: begin
        if (rst_cnt != 4'h0) begin
          next_rst_cnt = rst_cnt - 4'h1;
        end else if (pin_rst_n) begin
          next_state = crsc_pkg::ST_LOCK;
          next_lock_cnt = 16'h0000;
        end
      end
      crsc_pkg::ST_LOCK: begin
        // Bypass needs no settling time
        if (!loop_enable_out ||
            lock_cnt == 16'(LOCK_CYCLES - 1)) begin
          next_state = crsc_pkg::ST_RUN;
          next_fetch_start = 1'b1;
        end else begin
          next_lock_cnt = lock_cnt + 16'h0001;
        end
      end
      crsc_pkg::ST_RUN: begin
        if (halt_request_in) begin
          next_state = crsc_pkg::ST_HALT;
        end
      end
      crsc_pkg::ST_HALT: begin
        if (wake_event_in) begin
          next_state = crsc_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = crsc_pkg::ST_RESET;
      end
    endcase
    // Reset sources override every state
    if (!pin_rst_n) begin
      next_state = crsc_pkg::ST_RESET;
      next_rst_cnt = `CRSC_RST_HOLD;
      next_fetch_start = 1'b0;
      next_cause = 1'b0;
    end else if (wd_overflow) begin
      next_state = crsc_pkg::ST_RESET;
      next_rst_cnt = `CRSC_RST_HOLD;
      next_fetch_start = 1'b0;
      next_cause = 1'b1;
    end
  end

  // Straps follow the pins in reset, hold otherwise
  always_comb begin
    next_bus16 = bus_width_16_out;
    next_rom = internal_rom_enable_out;
    next_dbg = port_eight_pins_debug_out[0];
    next_loop = loop_enable_out;
    next_mult = loop_multiplier_out;
    if (state == crsc_pkg::ST_RESET) begin
      next_bus16 = pin_s[`CRSC_PIN_BUS];
      next_rom = pin_s[`CRSC_PIN_ROM];
      next_dbg = pin_s[`CRSC_PIN_DBG];
      next_loop = pin_s[`CRSC_PIN_LOOP];
      next_mult = pin_s[`CRSC_PIN_FREQ] ? `CRSC_MULT_LOW_FREQ
                                       : `CRSC_MULT_HIGH_FREQ;
    end
  end

  // Operating clock divider, ratio changes on a period boundary
  always_comb begin
    next_div_cnt = div_cnt + 2'h1;
    next_div_sel = div_sel;
    if (div_cnt == 2'h3) begin
      case (clock_divider_select_in)
        2'h0: next_div_sel = crsc_pkg::DIV_1;
        2'h1: next_div_sel = crsc_pkg::DIV_2;
        default: next_div_sel = crsc_pkg::DIV_4;
      endcase
    end
    case (div_sel)
      crsc_pkg::DIV_1: op_tick = 1'b1;
      crsc_pkg::DIV_2: op_tick = div_cnt[0];
      default: op_tick = (div_cnt == 2'h3);
    endcase
    next_clk_out = op_tick ? !system_clock_out : system_clock_out;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= crsc_pkg::ST_RESET;
      rst_cnt <= `CRSC_RST_HOLD;
      lock_cnt <= 16'h0000;
      fetch_start_out <= 1'b0;
      fetch_address_out <= `CRSC_RESET_VECTOR;
      watchdog_reset_cause_out <= 1'b0;
      system_reset_out <= 1'b1;
      cpu_clock_enable_out <= 1'b0;
      halted_out <= 1'b0;
      time_base_tick_out <= 1'b0;
      bus_width_16_out <= 1'b0;
      internal_rom_enable_out <= 1'b0;
      port_eight_pins_debug_out <= 8'h00;
      loop_enable_out <= 1'b0;
      loop_multiplier_out <= `CRSC_MULT_HIGH_FREQ;
      div_sel <= crsc_pkg::DIV_1;
      div_cnt <= 2'h0;
      system_clock_out <= 1'b0;
    end else begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
      lock_cnt <= next_lock_cnt;
      fetch_start_out <= next_fetch_start;
      fetch_address_out <= `CRSC_RESET_VECTOR;
      watchdog_reset_cause_out <= next_cause;
      system_reset_out <= (next_state == crsc_pkg::ST_RESET) ||
                          (next_state == crsc_pkg::ST_LOCK);
      cpu_clock_enable_out <= (next_state == crsc_pkg::ST_RUN);
      halted_out <= (next_state == crsc_pkg::ST_HALT);
      time_base_tick_out <= tb_tick;
      bus_width_16_out <= next_bus16;
      internal_rom_enable_out <= next_rom;
      port_eight_pins_debug_out <= {8{next_dbg}};
      loop_enable_out <= next_loop;
      loop_multiplier_out <= next_mult;
      div_sel <= next_div_sel;
      div_cnt <= next_div_cnt;
      system_clock_out <= next_clk_out;
    end
  end

  sequence seq_release;
    system_reset_out ##1 !system_reset_out;
  endsequence

  sequence seq_held_reset;
    system_reset_out [*8];
  endsequence

  a_pin_holds_reset: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !pin_rst_n |=> system_reset_out && state == crsc_pkg::ST_RESET)
    else $error("reset pin low but system not in reset");

  a_fetch_from_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    seq_release |-> fetch_start_out && fetch_address_out == 24'h000000)
    else $error("restart not from address zero");

  a_bus_width_capture: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state == crsc_pkg::ST_RESET |=>
      bus_width_16_out == $past(pin_s[`CRSC_PIN_BUS]))
    else $error("bus width strap not captured in reset");

  a_rom_strap_capture: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state == crsc_pkg::ST_RESET |=>
      internal_rom_enable_out == $past(pin_s[`CRSC_PIN_ROM]))
    else $error("rom strap not captured in reset");

  a_port_eight_mode: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state == crsc_pkg::ST_RESET |=>
      port_eight_pins_debug_out == {8{$past(pin_s[`CRSC_PIN_DBG])}})
    else $error("port eight function not set from strap");

  a_clock_out_toggles: assert property (
    @(posedge clk_in) disable iff (rst_in)
    op_tick |=> system_clock_out != $past(system_clock_out))
    else $error("clock output missed an operating tick");

  // Restart pulse must come out of a finished lock wait
  a_lock_wait_done: assert property (
    @(posedge clk_in) disable iff (rst_in)
    fetch_start_out |-> $past(state) == crsc_pkg::ST_LOCK &&
      (!loop_enable_out || $past(lock_cnt) == 16'(LOCK_CYCLES - 1)))
    else $error("run entered before loop settled");

  a_freq_range_mult: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state == crsc_pkg::ST_RESET |=> loop_multiplier_out ==
      ($past(pin_s[`CRSC_PIN_FREQ]) ? 3'h4 : 3'h2))
    else $error("multiplier does not follow frequency range strap");

  // Only while divide by four is kept at the period boundary
  a_div_four_rate: assert property (
    @(posedge clk_in) disable iff (rst_in)
    div_sel == crsc_pkg::DIV_4 && op_tick && clock_divider_select_in[1]
      |=> !op_tick [*3])
    else $error("divide by four ticks too often");

  a_halt_gates_cpu: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state == crsc_pkg::ST_RUN && halt_request_in && pin_rst_n
      && !wd_overflow |=> halted_out && !cpu_clock_enable_out)
    else $error("halt request did not stop the core clock");

  a_watchdog_reset: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wd_overflow && pin_rst_n |=>
      seq_held_reset ##0 watchdog_reset_cause_out)
    else $error("watchdog overflow did not force a full reset");

  a_straps_frozen: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !$past(rst_in) && $past(state) != crsc_pkg::ST_RESET
      |-> $stable(bus_width_16_out)
      && $stable(internal_rom_enable_out)
      && $stable(port_eight_pins_debug_out)
      && $stable(loop_enable_out) && $stable(loop_multiplier_out))
    else $error("strap result changed outside reset");

endmodule : crsc_top
`default_nettype wire

// >>> sim/crsc_board.sv
// Purpose: Board model driving the reset pin and the five straps
// Assumes: The bench sends level commands just after a clock edge
// Notes: Pins follow the commands one edge later, plus 2 ns
`default_nettype none
module crsc_board (
  // Clock
  input wire logic clk_in,
  // Commands from the bench
  input wire logic reset_low_in,
  input wire logic [4:0] strap_in,
  // Board pins
  output logic system_reset_n_out,
  output logic [4:0] strap_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin held low while reset is wanted, straps held at the chosen level
  initial begin
    system_reset_n_out = 1'b0;
    strap_out = 5'h00;
    forever begin
      @(posedge clk_in);
      system_reset_n_out <= #2 ~reset_low_in;
      strap_out <= #2 strap_in;
    end
  end
endmodule : crsc_board
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench of the clock, reset and strap controller
// Assumes: Short lock, time base and watchdog counts
// Notes: Strap bits are bus, rom, debug, loop, range from bit 0 up
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK = 8;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reset_low = 1'b1;
  logic [4:0] strap = 5'h00;
  logic [1:0] div_sel = 2'h0;
  logic halt_req = 1'b0;
  logic wake = 1'b0;
  logic wd_en = 1'b0;
  logic wd_clr = 1'b0;
  logic pin_n;
  logic [4:0] pins;
  logic sys_rst, fetch, cause, bus16, rom, loop_en, sclk, cpu_en;
  logic halted, tick;
  logic [23:0] faddr;
  logic [7:0] p8;
  logic [2:0] mult;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  int n_byp;
  int n_loop;
  int n;
  int exp_tg[4] = '{16, 8, 4, 4};

  crsc_board crsc_board_i (.clk_in(clk_in), .reset_low_in(reset_low),
    .strap_in(strap), .system_reset_n_out(pin_n), .strap_out(pins));

  crsc_top #(.LOCK_CYCLES(LOCK), .TB_DIV(4), .WDT_BITS(2)) crsc_top_i (
    .clk_in(clk_in), .rst_in(rst_in), .system_reset_in_n(pin_n),
    .boot_bus_width_strap_in(pins[0]),
    .internal_rom_enable_strap_in(pins[1]),
    .debug_select_strap_in(pins[2]), .loop_enable_strap_in(pins[3]),
    .base_freq_range_strap_in(pins[4]),
    .clock_divider_select_in(div_sel), .halt_request_in(halt_req),
    .wake_event_in(wake), .watchdog_enable_in(wd_en),
    .watchdog_clear_in(wd_clr), .system_reset_out(sys_rst),
    .fetch_start_out(fetch), .fetch_address_out(faddr),
    .watchdog_reset_cause_out(cause), .bus_width_16_out(bus16),
    .internal_rom_enable_out(rom), .port_eight_pins_debug_out(p8),
    .loop_enable_out(loop_en), .loop_multiplier_out(mult),
    .system_clock_out(sclk), .cpu_clock_enable_out(cpu_en),
    .halted_out(halted), .time_base_tick_out(tick));

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic end_of_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [23:0] seen,
      input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic step();
    @(posedge clk_in);
    #2;
  endtask : step

  task automatic wait_fetch(output int cnt);
    cnt = 0;
    while (fetch !== 1'b1 && cnt < 400) begin
      step();
      cnt++;
    end
    check("fetch_start", 24'(fetch), 24'h1);
    check("fetch_addr", faddr, 24'h000000);
    check("sys_rst_run", 24'(sys_rst), 24'h0);
  endtask : wait_fetch

  task automatic pin_reset(input logic [4:0] s, output int cnt);
    strap = s;
    reset_low = 1'b1;
    repeat (12) step();
    check("sys_rst_pin", 24'(sys_rst), 24'h1);
    reset_low = 1'b0;
    wait_fetch(cnt);
    check("wd_cause", 24'(cause), 24'h0);
  endtask : pin_reset

  task automatic check_straps(input logic [4:0] s);
    check("bus16", 24'(bus16), 24'(s[0]));
    check("rom", 24'(rom), 24'(s[1]));
    check("port8", 24'(p8), 24'({8{s[2]}}));
    check("loop", 24'(loop_en), 24'(s[3]));
    check("mult", 24'(mult), s[4] ? 24'h4 : 24'h2);
  endtask : check_straps

  task automatic div_check(input logic [1:0] sel, input int exp);
    int tg;
    int tk;
    logic last;
    tg = 0;
    tk = 0;
    div_sel = sel;
    repeat (8) step();
    last = sclk;
    repeat (16) begin
      step();
      tg += int'(sclk !== last);
      tk += int'(tick === 1'b1);
      last = sclk;
    end
    check("clk_toggles", 24'(tg), 24'(exp));
    check("tb_ticks", 24'(tk), 24'h4);
  endtask : div_check

  initial begin
    repeat (2) step();
    rst_in = 1'b0;
    check("sys_rst_por", 24'(sys_rst), 24'h1);
    pin_reset(5'h15, n_byp);
    check_straps(5'h15);
    // Straps moved after release must not reach the outputs
    strap = 5'h0A;
    repeat (10) step();
    check_straps(5'h15);
    pin_reset(5'h0A, n_loop);
    check_straps(5'h0A);
    check("lock_wait", 24'(n_loop - n_byp), 24'(LOCK - 1));
    for (int i = 0; i < 4; i++) begin
      div_check(2'(i), exp_tg[i]);
    end
    halt_req = 1'b1;
    step();
    halt_req = 1'b0;
    check("halted", 24'(halted), 24'h1);
    check("cpu_en_halt", 24'(cpu_en), 24'h0);
    repeat (3) step();
    wake = 1'b1;
    step();
    wake = 1'b0;
    check("woken", 24'(halted), 24'h0);
    check("cpu_en_run", 24'(cpu_en), 24'h1);
    // Watchdog restart must re-latch the new strap pattern
    strap = 5'h15;
    wd_en = 1'b1;
    n = 0;
    while (sys_rst !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    check("wd_reset", 24'(sys_rst), 24'h1);
    check("wd_cause", 24'(cause), 24'h1);
    wait_fetch(n);
    check_straps(5'h15);
    wd_clr = 1'b1;
    n = 0;
    repeat (60) begin
      step();
      n += int'(sys_rst !== 1'b0);
    end
    check("wd_cleared", 24'(n), 24'h0);
    wd_en = 1'b0;
    wd_clr = 1'b0;
    pin_reset(5'h0A, n);
    check_straps(5'h0A);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
